// ===== pmlb_map.svh
// Address map, field positions and reset values of the logic-block group
`ifndef PMLB_MAP_SVH
`define PMLB_MAP_SVH
`define PMLB_MC_N 16
`define PMLB_ROUTE_N 36
`define PMLB_SRC_N 52
`define PMLB_PT_N 5
`define PMLB_PT_WORDS 4
`define PMLB_CHAIN 8
`define PMLB_PAR_MAX 3
`define PMLB_CFG_WORDS 346
`define PMLB_IDX_PT 9'h000
`define PMLB_IDX_MC 9'h140
`define PMLB_IDX_RT 9'h150
`define PMLB_IDX_GLB 9'h159
`define PMLB_IDX_STAT 9'h15A
`define PMLB_MC_TYPE 0
`define PMLB_MC_BYP 2
`define PMLB_MC_MODE 3
`define PMLB_MC_GSEL 5
`define PMLB_MC_DEST 8
`define PMLB_MC_XINV 23
`define PMLB_MC_GCLR 24
`define PMLB_MC_FAST 25
`define PMLB_MC_PSETS 26
`define PMLB_RT_PER_WORD 4
`define PMLB_RT_FLD 8
`define PMLB_GLB_ENH 0
`define PMLB_GLB_G0PIN 1
`define PMLB_GLB_G0INV 2
`define PMLB_GLB_G1PIN 3
`define PMLB_GLB_G1INV 4
`define PMLB_GLB_DCTL 5
`define PMLB_CFG_RST 32'h0000_0000
`endif

// ===== pmlb_pkg.sv
// Types shared by the logic-block group design
package pmlb_pkg;
  typedef enum logic [1:0] {
    PMLB_FF_D = 2'h0, PMLB_FF_T = 2'h1, PMLB_FF_JK = 2'h2, PMLB_FF_SR = 2'h3
  } pmlb_ff_t;
  typedef enum logic [1:0] {
    PMLB_CK_GLOBAL = 2'h0, PMLB_CK_GLOBAL_CE = 2'h1, PMLB_CK_ARRAY = 2'h2
  } pmlb_clk_t;
  typedef enum logic [2:0] {
    PMLB_DST_OR = 3'h0, PMLB_DST_CLR = 3'h1, PMLB_DST_PRE = 3'h2,
    PMLB_DST_CLK = 3'h3, PMLB_DST_CE = 3'h4, PMLB_DST_SEXP = 3'h5,
    PMLB_DST_LEND = 3'h6, PMLB_DST_KR = 3'h7
  } pmlb_dest_t;
endpackage

// ===== pmlb_cfg_mem.sv
// Configuration word memory with registered read port
`timescale 1ns/1ps
`include "pmlb_map.svh"
module pmlb_cfg_mem (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_we, // Write strobe
  input wire logic [8:0] i_waddr, // Write word index
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [8:0] i_raddr, // Read word index
  output logic [31:0] o_rdata, // Registered read data
  output logic [31:0] o_words [`PMLB_CFG_WORDS] // All words, live
);
  logic [31:0] mem_ff [`PMLB_CFG_WORDS]; // Storage
  logic [31:0] rdata_ff; // Read register
  // Storage, cleared to the erased state
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < `PMLB_CFG_WORDS; i++) begin
        mem_ff[i] <= `PMLB_CFG_RST;
      end
    end else if (i_we && (i_waddr < `PMLB_IDX_STAT)) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end
  // Read port, one cycle latency
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_raddr < `PMLB_IDX_STAT) begin
      rdata_ff <= mem_ff[i_raddr];
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end
  assign o_rdata = rdata_ff;
  assign o_words = mem_ff;
endmodule

// ===== pmlb_mcell.sv
// One macrocell register with clocking mode, type and async controls
`timescale 1ns/1ps
module pmlb_mcell (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_sum, // Logic result, D, T, J or S data
  input wire logic i_kr, // K or R data
  input wire logic i_fast_d, // Fast input path from pin
  input wire logic i_fast_en, // Take D from fast path
  input wire pmlb_pkg::pmlb_ff_t i_type, // Storage element type
  input wire logic i_bypass, // Combinational output
  input wire pmlb_pkg::pmlb_clk_t i_mode, // Clocking mode
  input wire logic i_gevt, // Selected global clock edge
  input wire logic i_ce, // Clock enable level
  input wire logic i_aclk, // Array clock level
  input wire logic i_clr, // Async clear, active high
  input wire logic i_pre, // Async preset, active high
  output logic o_q, // Stored state
  output logic o_out // Macrocell output
);
  logic q_ff; // Register state
  logic aclk_prev_ff; // Array clock history
  logic nxt_q; // Value taken at capture
  logic upd; // Capture this cycle
  logic d; // Data input
  // Array clock history for edge detect
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aclk_prev_ff <= 1'h0;
    end else begin
      aclk_prev_ff <= i_aclk;
    end
  end
  // Capture condition per clocking mode
  always_comb begin
    case (i_mode)
      pmlb_pkg::PMLB_CK_GLOBAL: upd = i_gevt;
      pmlb_pkg::PMLB_CK_GLOBAL_CE: upd = i_gevt & i_ce;
      pmlb_pkg::PMLB_CK_ARRAY: upd = i_aclk & ~aclk_prev_ff;
      default: upd = 1'h0;
    endcase
  end
  assign d = i_fast_en ? i_fast_d : i_sum;
  // Next state per element type
  always_comb begin
    case (i_type)
      pmlb_pkg::PMLB_FF_D: nxt_q = d;
      pmlb_pkg::PMLB_FF_T: nxt_q = q_ff ^ d;
      pmlb_pkg::PMLB_FF_JK: nxt_q = (d & ~q_ff) | (~i_kr & q_ff);
      pmlb_pkg::PMLB_FF_SR: nxt_q = (d & ~i_kr) | (q_ff & ~i_kr) | (d & q_ff);
      default: nxt_q = q_ff;
    endcase
  end
  // Register: clear beats preset, both beat capture
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q_ff <= 1'h0;
    end else if (i_clr) begin
      q_ff <= 1'h0;
    end else if (i_pre) begin
      q_ff <= 1'h1;
    end else if (upd) begin
      q_ff <= nxt_q;
    end
  end
  // Output: sum when bypassed, else async controls shown at once
  always_comb begin
    if (i_bypass) begin
      o_out = i_sum;
    end else if (i_clr) begin
      o_out = 1'h0;
    end else if (i_pre) begin
      o_out = 1'h1;
    end else begin
      o_out = q_ff;
    end
  end
  assign o_q = q_ff;
endmodule

// ===== pmlb_top.sv
// Logic-block group of sixteen macrocells with its APB config port
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "pmlb_map.svh"
module pmlb_top (
  input wire logic i_sys_clk, // System clock, 125 MHz
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [11:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error
  input wire logic i_primary_global_clock_pin, // Dedicated input 0
  input wire logic i_global_clear_pin_n, // Dedicated input 1
  input wire logic i_output_enable_pin_one, // Dedicated input 2
  input wire logic i_output_enable_pin_two, // Dedicated 3, also clock two
  input wire logic [15:0] i_io_pin, // Pin levels, one per macrocell
  input wire logic [15:0] i_peer_mc, // Other groups' outputs
  output logic [15:0] o_mc_out, // Macrocell outputs
  output logic [1:0] o_global_oe // Global output enables
);
  logic [31:0] cfg [`PMLB_CFG_WORDS]; // Live config words
  logic [31:0] mem_rdata; // Config read data
  logic [31:0] glb; // Global config word
  logic [8:0] idx; // Word index of access
  logic mapped; // Address hits the map
  logic bad; // Access to be refused
  logic access; // APB access phase
  logic mem_we; // Config write strobe
  logic [1:0] rd_sel_ff; // Read source of access
  logic [31:0] stat_ff; // Status snapshot
  logic [1:0] oe_ff; // Global output enables
  logic [3:0] dctl; // Dedicated inputs as controls
  logic [3:0] ded; // Dedicated input levels
  logic [`PMLB_SRC_N-1:0] src; // Routing sources
  logic [`PMLB_ROUTE_N-1:0] route; // Routed general inputs
  logic [15:0] sexp; // Shareable expander levels
  logic [`PMLB_SRC_N-1:0] lit; // Array literals
  logic [15:0] orv; // OR terms per macrocell
  logic [15:0] clrv; // Clear terms
  logic [15:0] prev; // Preset terms
  logic [15:0] ckv; // Array clock terms
  logic [15:0] cev; // Enable terms
  logic [15:0] ceh; // Enable term present
  logic [15:0] lend; // Terms lent to neighbours
  logic [15:0] krv; // K or R terms
  logic [15:0] par; // Borrowed terms
  logic [15:0] sum; // OR/XOR result
  logic [15:0] clr; // Effective clear
  logic [15:0] ce; // Effective enable
  logic [15:0] mc_q; // Register states
  logic [15:0] fast_en; // Fast path in use
  logic [15:0] gevt_mc; // Clock edge per macrocell
  logic gclr_act; // Global clear asserted
  logic [1:0] gclk; // Global clock levels
  logic [1:0] gclk_prev_ff; // Global clock history
  logic [1:0] gevt; // Global clock rising edges
  logic [31:0] mcw [`PMLB_MC_N]; // Control word per macrocell

  // AND of chosen literals; an empty term stays low
  function automatic logic pterm(input logic [51:0] l, input logic [51:0] tm,
                                 input logic [51:0] cm);
    pterm = (|{tm, cm}) & (&(l | ~tm)) & (&(~l | ~cm));
  endfunction

  // First config word of a product term
  function automatic int pt_base(input int m, input int t);
    pt_base = `PMLB_PT_WORDS * (`PMLB_PT_N * m + t);
  endfunction

  // True-literal mask of a term
  function automatic logic [51:0] tmask(input int m, input int t);
    tmask = {cfg[pt_base(m, t) + 1][19:0], cfg[pt_base(m, t)]};
  endfunction

  // Complement-literal mask of a term
  function automatic logic [51:0] cmask(input int m, input int t);
    cmask = {cfg[pt_base(m, t) + 3][19:0], cfg[pt_base(m, t) + 2]};
  endfunction

  // Control word of a macrocell
  function automatic logic [31:0] ctl(input int m);
    ctl = cfg[`PMLB_IDX_MC + m];
  endfunction

  // Destination of a term in the select matrix
  function automatic pmlb_pkg::pmlb_dest_t dest_of(input int m, input int t);
    dest_of = pmlb_pkg::pmlb_dest_t'(mcw[m][`PMLB_MC_DEST + 3 * t +: 3]);
  endfunction

  // Config storage
  pmlb_cfg_mem u_cfg (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_we(mem_we),
    .i_waddr(idx),
    .i_wdata(i_pwdata),
    .i_raddr(idx),
    .o_rdata(mem_rdata),
    .o_words(cfg)
  );

  // Control words gathered once, so fields can be sliced
  always_comb begin
    for (int m = 0; m < `PMLB_MC_N; m++) begin
      mcw[m] = ctl(m);
    end
  end

  // APB decode: aligned words up to status
  assign idx = i_paddr[10:2];
  assign access = i_psel & i_penable;
  assign mapped = ~i_paddr[11] & (i_paddr[1:0] == 2'h0) & (idx <= `PMLB_IDX_STAT);
  assign bad = ~mapped | (i_pwrite & (idx == `PMLB_IDX_STAT));
  assign mem_we = access & i_pwrite & ~bad;
  assign o_pready = access;
  assign o_pslverr = access & bad;

  // Read source chosen from the held address
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_sel_ff <= 2'h0;
    end else if (!mapped) begin
      rd_sel_ff <= 2'h0;
    end else if (idx == `PMLB_IDX_STAT) begin
      rd_sel_ff <= 2'h2;
    end else begin
      rd_sel_ff <= 2'h1;
    end
  end

  // Status snapshot: outputs high, states low
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_ff <= 32'h0000_0000;
    end else begin
      stat_ff <= {o_mc_out, mc_q};
    end
  end

  // Read data mux of registered sources
  always_comb begin
    case (rd_sel_ff)
      2'h1: o_prdata = mem_rdata;
      2'h2: o_prdata = stat_ff;
      default: o_prdata = 32'h0000_0000;
    endcase
  end

  // Dedicated inputs and their role
  assign glb = cfg[`PMLB_IDX_GLB];
  assign dctl = glb[`PMLB_GLB_DCTL +: 4];
  assign ded = {i_output_enable_pin_two, i_output_enable_pin_one,
                i_global_clear_pin_n, i_primary_global_clock_pin};
  assign gclr_act = dctl[1] & ~i_global_clear_pin_n;

  // Global output enables from active-low pins
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oe_ff <= 2'h0;
    end else begin
      oe_ff <= dctl[3:2] & ~ded[3:2];
    end
  end
  assign o_global_oe = oe_ff;

  // Global clock selection per variant
  always_comb begin
    if (glb[`PMLB_GLB_ENH]) begin
      gclk[0] = (glb[`PMLB_GLB_G0PIN] ? ded[3] : ded[0]) ^ glb[`PMLB_GLB_G0INV];
      gclk[1] = (glb[`PMLB_GLB_G1PIN] ? ded[3] : ded[0]) ^ glb[`PMLB_GLB_G1INV];
    end else begin
      gclk = {2{ded[0]}};
    end
  end

  // Global clock history for edge detect
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gclk_prev_ff <= 2'h0;
    end else begin
      gclk_prev_ff <= gclk;
    end
  end
  assign gevt = gclk & ~gclk_prev_ff;

  // Routing sources: general dedicated, pins, macrocells
  assign src = {i_peer_mc, mc_q, i_io_pin, ded & ~dctl};

  // Select thirty-six routed inputs
  always_comb begin
    logic [5:0] sel;
    sel = 6'h00;
    route = '0;
    for (int k = 0; k < `PMLB_ROUTE_N; k++) begin
      sel = cfg[`PMLB_IDX_RT + k / `PMLB_RT_PER_WORD][`PMLB_RT_FLD * (k % `PMLB_RT_PER_WORD) +: 6];
      if (sel < 6'(`PMLB_SRC_N)) begin
        route[k] = src[sel];
      end
    end
  end

  // Shareable expanders from routed inputs only
  always_comb begin
    logic acc; // Term OR of one macrocell
    logic [51:0] tm; // True mask of a term
    logic [51:0] cm; // Complement mask of a term
    acc = 1'h0;
    tm = '0;
    cm = '0;
    sexp = '0;
    for (int m = 0; m < `PMLB_MC_N; m++) begin
      acc = 1'h0;
      for (int t = 0; t < `PMLB_PT_N; t++) begin
        if (dest_of(m, t) == pmlb_pkg::PMLB_DST_SEXP) begin
          tm = tmask(m, t);
          cm = cmask(m, t);
          acc = acc | pterm({16'h0000, route}, {16'h0000, tm[35:0]}, {16'h0000, cm[35:0]});
        end
      end
      sexp[m] = ~acc;
    end
  end

  // Literals shared by all macrocells of the group
  assign lit = {sexp, route};

  // Term evaluation and select matrix
  always_comb begin
    logic v;
    v = 1'h0;
    orv = '0;
    clrv = '0;
    prev = '0;
    ckv = '0;
    cev = '0;
    ceh = '0;
    lend = '0;
    krv = '0;
    for (int m = 0; m < `PMLB_MC_N; m++) begin
      for (int t = 0; t < `PMLB_PT_N; t++) begin
        v = pterm(lit, tmask(m, t), cmask(m, t));
        case (dest_of(m, t))
          pmlb_pkg::PMLB_DST_OR: orv[m] = orv[m] | v;
          pmlb_pkg::PMLB_DST_CLR: clrv[m] = clrv[m] | v;
          pmlb_pkg::PMLB_DST_PRE: prev[m] = prev[m] | v;
          pmlb_pkg::PMLB_DST_CLK: ckv[m] = ckv[m] | v;
          pmlb_pkg::PMLB_DST_CE: begin
            cev[m] = cev[m] | v;
            ceh[m] = 1'h1;
          end
          pmlb_pkg::PMLB_DST_LEND: lend[m] = lend[m] | v;
          pmlb_pkg::PMLB_DST_KR: krv[m] = krv[m] | v;
          default: ;
        endcase
      end
    end
  end

  // Parallel expanders from lower neighbours in the chain
  always_comb begin
    int sets;
    sets = 0;
    par = '0;
    for (int m = 0; m < `PMLB_MC_N; m++) begin
      sets = int'(mcw[m][`PMLB_MC_PSETS +: 2]);
      for (int k = 1; k <= `PMLB_PAR_MAX; k++) begin
        if ((k <= sets) && (k <= m % `PMLB_CHAIN)) begin
          par[m] = par[m] | lend[m - k];
        end
      end
    end
  end

  // OR/XOR result, clear, enable and fast path per macrocell
  always_comb begin
    for (int m = 0; m < `PMLB_MC_N; m++) begin
      sum[m] = (orv[m] | par[m]) ^ mcw[m][`PMLB_MC_XINV];
      clr[m] = clrv[m] | (mcw[m][`PMLB_MC_GCLR] & gclr_act);
      ce[m] = ceh[m] ? cev[m] : 1'h1;
      fast_en[m] = mcw[m][`PMLB_MC_FAST] & glb[`PMLB_GLB_ENH];
      gevt_mc[m] = gevt[mcw[m][`PMLB_MC_GSEL]];
    end
  end

  // Sixteen macrocells of the group
  for (genvar m = 0; m < `PMLB_MC_N; m++) begin : g_mc
    pmlb_mcell u_mc (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_sum(sum[m]),
      .i_kr(krv[m]),
      .i_fast_d(i_io_pin[m]),
      .i_fast_en(fast_en[m]),
      .i_type(pmlb_pkg::pmlb_ff_t'(mcw[m][`PMLB_MC_TYPE +: 2])),
      .i_bypass(mcw[m][`PMLB_MC_BYP]),
      .i_mode(pmlb_pkg::pmlb_clk_t'(mcw[m][`PMLB_MC_MODE +: 2])),
      .i_gevt(gevt_mc[m]),
      .i_ce(ce[m]),
      .i_aclk(ckv[m]),
      .i_clr(clr[m]),
      .i_pre(prev[m]),
      .o_q(mc_q[m]),
      .o_out(o_mc_out[m])
    );
  end
endmodule

// ===== pmlb_checker.sv
// Port checks for the logic-block group
`timescale 1ns/1ps
module pmlb_checker (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [11:0] i_paddr, // APB byte address
  input wire logic [31:0] o_prdata, // APB read data
  input wire logic o_pready, // APB ready
  input wire logic o_pslverr, // APB error
  input wire logic [15:0] o_mc_out, // Macrocell outputs
  input wire logic [1:0] o_global_oe // Global output enables
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // Access phase of a transfer
  logic acc;
  assign acc = i_psel & i_penable;
  // Address outside the map
  logic bad;
  assign bad = i_paddr[11] | (i_paddr[1:0] != 2'h0) | (i_paddr > 12'h568);
  // Status word written
  logic stwr;
  assign stwr = i_pwrite & (i_paddr == 12'h568);
  ready_access_a: assert property (acc |-> o_pready) else $error("no ready in access");
  setup_quiet_a: assert property (i_psel && !i_penable |-> !o_pready) else $error("ready in setup");
  ready_idle_a: assert property (!i_psel |-> !o_pready && !o_pslverr) else $error("answer while idle");
  err_refuse_a: assert property (acc && bad |-> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("bad address not refused");
  err_status_a: assert property (acc && stwr |-> o_pslverr) else $error("status write not refused");
  err_quiet_a: assert property (acc && !bad && !stwr |-> !o_pslverr) else $error("error on good access");
  err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  reset_low_a: assert property ($rose(i_rstn) |-> o_mc_out == 16'h0000 && o_global_oe == 2'h0)
    else $error("outputs not low after reset");
endmodule
bind pmlb_top pmlb_checker i_pmlb_checker (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_mc_out(o_mc_out), .o_global_oe(o_global_oe));

// ===== pmlb_top_test.sv
// Self-checking bench for the logic-block group
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("FAIL %s exp %h got %h", n, e, g); end end
module pmlb_top_test;
  localparam logic [31:0] CTL = 32'h0008_8800; // Term 1 clear, 2 preset, 3 enable
  localparam logic [31:0] CTLK = 32'h000E_8800; // Term 3 as K or R
  localparam logic [11:0] BAD [4] = '{12'h800, 12'h002, 12'h568, 12'h56C}; // Refused places
  // Expander, array clock and second clock setup: places and words
  localparam logic [11:0] XA [12] = '{12'h540, 12'h000, 12'h010, 12'h054, 12'h500, 12'h504, 12'h0A0,
    12'h0B0, 12'h508, 12'h0F0, 12'h50C, 12'h564};
  localparam logic [31:0] XD [12] = '{32'h0706_0504, 32'h0000_0001, 32'h0000_0002, 32'h0000_0010,
    32'h0000_2E00, 32'h0480_0004, 32'h0000_0001, 32'h0000_0004, 32'h0000_1810, 32'h0000_0001,
    32'h0000_0020, 32'h0000_0009};
  logic clk = 1'b0; // System clock
  logic rstn, psel, pen, pwr, rdy, err, gck, gclr_n, oe1, oe2; // Pins and bus controls
  logic [11:0] addr; // Bus address
  logic [31:0] wdata, rdata, rd, wd; // Bus data
  logic [15:0] io, peer, mco; // Pins, routed peers, outputs
  logic [1:0] goe; // Global output enables
  logic q, d; // Modelled state and error flag of the last transfer
  int errors = 0; // Mismatches
  int checked = 0; // Comparisons
  int cyc = 0; // Cycle count
  pmlb_top i_pmlb_top (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy), .o_pslverr(err),
    .i_primary_global_clock_pin(gck), .i_global_clear_pin_n(gclr_n), .i_output_enable_pin_one(oe1),
    .i_output_enable_pin_two(oe2), .i_io_pin(io), .i_peer_mc(peer), .o_mc_out(mco), .o_global_oe(goe));
  // Clock, 8 ns period
  always #4 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  // Verdict and end of run
  task stop_test;
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer, then one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= dd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1);
    `CHK("wait", 1, n)
    rd = rdata;
    d = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Next state of each storage element type
  function automatic logic nxt_q(input pmlb_pkg::pmlb_ff_t t, input logic qq, input logic s, input logic r);
    case (t)
      pmlb_pkg::PMLB_FF_T: return qq ^ s;
      pmlb_pkg::PMLB_FF_JK: return (s & ~qq) | (~r & qq);
      pmlb_pkg::PMLB_FF_SR: return (s & ~r) | (qq & ~r) | (s & qq);
      default: return s;
    endcase
  endfunction
  // One full pulse on the clock pin
  task pulse;
    gck <= 1'b1;
    tick(4);
    gck <= 1'b0;
    tick(4);
  endtask
  // Present data, clock it, update the model
  task clock_in(input pmlb_pkg::pmlb_ff_t t, input logic s, input logic r);
    io[0] <= s;
    io[3] <= r;
    tick(1);
    pulse();
    q = nxt_q(t, q, s, r);
  endtask
  // Main sequence
  initial begin
    {rstn, psel, pen, pwr, gck, oe1} = 6'h00;
    {gclr_n, oe2} = 2'h3;
    addr = 12'h000;
    wdata = 32'h0000_0000;
    io = 16'h0000;
    void'($urandom(58675));
    peer = 16'($urandom);
    tick(4);
    rstn <= 1'b1;
    tick(1);
    `CHK("reset", 18'h0_0000, {goe, mco})
    // Refused places
    foreach (BAD[i]) begin
      apb(BAD[i] == 12'h568, BAD[i], 32'hFFFF_FFFF);
      `CHK("slverr", 1'b1, d)
      `CHK("bad rd", 32'h0000_0000, rd)
    end
    // Random term words of upper macrocells
    repeat (6) begin
      addr <= 12'h280 + 12'($urandom_range(39, 0)) * 12'h010;
      wd = $urandom;
      tick(1);
      apb(1'b1, addr, wd);
      apb(1'b0, addr, 32'h0000_0000);
      `CHK("cfg", wd, rd)
    end
    // Macrocell 0: term 0 = pin 0, terms 1..3 = pins 1..3
    apb(1'b1, 12'h540, 32'h0706_0504);
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h010, 32'h0000_0002);
    apb(1'b1, 12'h020, 32'h0000_0004);
    apb(1'b1, 12'h030, 32'h0000_0008);
    apb(1'b1, 12'h500, CTL);
    q = 1'b0;
    repeat (6) begin
      clock_in(pmlb_pkg::PMLB_FF_D, 1'($urandom), 1'($urandom));
      `CHK("dff", q, mco[0])
    end
    io[0] <= ~q;
    tick(3);
    `CHK("hold", q, mco[0])
    // Async clear and preset
    clock_in(pmlb_pkg::PMLB_FF_D, 1'b1, 1'b0);
    io[1] <= 1'b1;
    tick(2);
    `CHK("clr", 1'b0, mco[0])
    pulse();
    `CHK("clr cap", 1'b0, mco[0])
    io[2] <= 1'b1;
    tick(2);
    `CHK("clr pre", 1'b0, mco[0])
    io[1] <= 1'b0;
    tick(2);
    `CHK("pre", 1'b1, mco[0])
    io[2] <= 1'b0;
    tick(2);
    q = 1'b1;
    `CHK("pre held", q, mco[0])
    apb(1'b0, 12'h568, 32'h0000_0000);
    `CHK("stat out", 1'b1, rd[16])
    `CHK("stat q", 1'b1, rd[0])
    // Clock enable mode
    apb(1'b1, 12'h500, CTL | 32'h0000_0008);
    for (int e = 0; e < 2; e++) begin
      wd[0] = ~q;
      io[3] <= e[0];
      io[0] <= wd[0];
      tick(1);
      pulse();
      if (e == 1) q = wd[0];
      `CHK("ce", q, mco[0])
    end
    // T, JK and SR types
    for (int t = 1; t < 4; t++) begin
      apb(1'b1, 12'h500, CTLK | 32'(t));
      repeat (6) begin
        clock_in(pmlb_pkg::pmlb_ff_t'(t), 1'($urandom), 1'($urandom));
        `CHK("type", q, mco[0])
      end
    end
    // Flip-flop bypass
    apb(1'b1, 12'h500, CTL | 32'h0000_0004);
    repeat (4) begin
      wd[0] = 1'($urandom);
      io[0] <= wd[0];
      tick(1);
      `CHK("bypass", wd[0], mco[0])
    end
    // Global clear pin and output enables
    apb(1'b1, 12'h500, CTL | 32'h0100_0000);
    apb(1'b1, 12'h564, 32'h0000_01C0);
    clock_in(pmlb_pkg::PMLB_FF_D, 1'b1, 1'b0);
    gclr_n <= 1'b0;
    tick(2);
    `CHK("gclr", 1'b0, mco[0])
    `CHK("oe", 2'h1, goe)
    gclr_n <= 1'b1;
    // Inverted clock and fast pin path
    io[0] <= 1'b0;
    apb(1'b1, 12'h500, CTL | 32'h0200_0000);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h564, 32'h0000_01C5);
    io[0] <= 1'b1;
    gck <= 1'b1;
    tick(4);
    `CHK("inv rise", 1'b0, mco[0])
    gck <= 1'b0;
    tick(4);
    `CHK("inv fall", 1'b1, mco[0])
    // Reset in mid-run
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(1);
    `CHK("rerun", 16'h0000, mco)
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK("cfg clr", 32'h0000_0000, rd)
    // Macrocell 1: shareable term of pin 1, borrowed term of pin 0, inverted
    foreach (XA[i]) begin
      apb(1'b1, XA[i], XD[i]);
    end
    repeat (4) begin
      wd[1:0] = 2'($urandom);
      io[1:0] <= wd[1:0];
      tick(1);
      `CHK("expand", wd[1] & ~wd[0], mco[1])
    end
    // Macrocell 2: array clock from pin 2, data from pin 0
    for (int e = 0; e < 2; e++) begin
      io[0] <= ~e[0];
      tick(1);
      io[2] <= 1'b1;
      tick(2);
      `CHK("aclk", ~e[0], mco[2])
      io[2] <= 1'b0;
      io[0] <= e[0];
      tick(2);
      `CHK("aclk hold", ~e[0], mco[2])
    end
    // Macrocell 3: second global clock from pin two only
    io[0] <= 1'b0;
    oe2 <= 1'b0;
    tick(2);
    oe2 <= 1'b1;
    tick(2);
    `CHK("clk2", 1'b0, mco[3])
    io[0] <= 1'b1;
    gck <= 1'b1;
    tick(2);
    `CHK("clk2 only", 1'b0, mco[3])
    stop_test();
  end
endmodule
